// file: mdbc_pkg.sv
// Summary of operation
// - Bond status 00 means word sync seen; 01 asks to add one K28.5.
// - Bond status 10 deletes the next framing character; 11 is normal data.
// - Bond status changes on the same edge as the receive data outputs.
// - Status bus driven only as master, all four bonded, receive on reference clock.
// - Lead select low makes master with status pins out; high makes them inputs.
// - Lead select is honoured only in quad bonding on reference clock.
// - All-aligned flag is open-drain wired-AND, high only when every lane framed.
// - All-aligned flag driven only when four bonded on reference clock.
// - Inhibit low blocks offset adjust until every bonded lane saw the sequence.
// - Inhibit high lets each lane that saw the sequence align on its own.
// - Without the master channel in the group no lane bonds.
// - Test mode select high for five test clocks resets the test controller.
// - Test data output is driven only in the data and instruction shift states, released otherwise.
// - Test and device reset low resets the test controller asynchronously.
// - Reset sampled low resets state machines and centres buffer pointers.
// - After reset release outputs are deterministic in under 16 clocks.
// - Self-test, output enable and lane enable latches clear on device reset.
package mdbc_pkg;
  localparam logic [1:0] MDBC_CODE_SYNC   = 2'h0;
  localparam logic [1:0] MDBC_CODE_INSERT = 2'h1;
  localparam logic [1:0] MDBC_CODE_DELETE = 2'h2;
  localparam logic [1:0] MDBC_CODE_NORMAL = 2'h3;

  localparam logic [7:0] MDBC_OFS_CTRL    = 8'h00;
  localparam logic [7:0] MDBC_OFS_STATE   = 8'h04;
  localparam logic [7:0] MDBC_OFS_IRQ_ST  = 8'h08;
  localparam logic [7:0] MDBC_OFS_IRQ_EN  = 8'h0C;
  localparam logic [7:0] MDBC_OFS_IRQ_CLR = 8'h10;

  localparam logic [31:0] MDBC_CTRL_RESET   = 32'h0000_0001;
  localparam logic [3:0]  MDBC_IRQ_EN_RESET = 4'h0;
  localparam logic [3:0]  MDBC_EB_NOMINAL   = 4'h8;
  localparam int          MDBC_IRQ_BITS     = 4;

  localparam logic [3:0] MDBC_SETTLE_CYCLES = 4'h8;
  localparam int         MDBC_SETTLE_LIMIT  = 16;
  localparam logic [2:0] MDBC_TMS_RESET_CNT = 3'h5;

  localparam logic [1:0] MDBC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] MDBC_RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    MDBC_TLR = 4'h0, MDBC_RTI = 4'h1, MDBC_SDR = 4'h3, MDBC_CDR = 4'h2,
    MDBC_SHDR = 4'h6, MDBC_E1DR = 4'h7, MDBC_PDR = 4'h5, MDBC_E2DR = 4'h4,
    MDBC_UDR = 4'hC, MDBC_SIR = 4'hD, MDBC_CIR = 4'hF, MDBC_SHIR = 4'hE,
    MDBC_E1IR = 4'hA, MDBC_PIR = 4'hB, MDBC_E2IR = 4'h9, MDBC_UIR = 4'h8
  } mdbc_tap_e;
endpackage

// file: mdbc_sync.sv
`timescale 1ns/1ps
module mdbc_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // mdbc_sync

// file: mdbc_top.sv
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module mdbc_top
  import mdbc_pkg::*;
#(
  parameter int LANES = 4
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic                  irq,
  input  wire logic             test_and_device_reset_n,
  input  wire logic             lead_select_n,
  input  wire logic             quad_bond,
  input  wire logic             rx_on_ref_clock,
  input  wire logic             align_inhibit_n,
  input  wire logic             master_in_group,
  input  wire logic [LANES-1:0] lane_framed,
  input  wire logic [LANES-1:0] lane_bond_seen,
  input  wire logic [1:0]       local_status,
  input  wire logic [39:0]      rx_word_in,
  output logic [39:0]           rx_word_out,
  input  wire logic [1:0]       bond_status_bus_i,
  output logic [1:0]            bond_status_bus_o,
  output logic [1:0]            bond_status_bus_oe,
  input  wire logic             all_aligned_i,
  output logic                  all_aligned_o,
  output logic                  all_aligned_oe,
  output logic [LANES-1:0]      align_permit,
  output logic                  eb_resync,
  output logic                  eb_insert,
  output logic                  eb_delete,
  output logic [3:0]            eb_pointer,
  input  wire logic             selftest_latch_enable,
  input  wire logic             output_enable_latch_enable,
  input  wire logic             rx_lane_latch_enable,
  input  wire logic [3:0]       latch_data,
  output logic [3:0]            selftest_en,
  output logic [3:0]            output_en,
  output logic [3:0]            rx_lane_en,
  input  wire logic             tms,
  input  wire logic             tck,
  input  wire logic             tdi,
  output logic                  tdo_o,
  output logic                  tdo_oe
);
  logic [10:0] pin_s;
  logic        lead_s, quad_s, ref_s, inh_s, all_in_s, tms_s, tck_s, tdi_s, trst_s;
  logic [1:0]  bus_s;
  logic [2:0]  le_s;

  mdbc_sync #(.W(11)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({test_and_device_reset_n, lead_select_n, quad_bond, rx_on_ref_clock,
                align_inhibit_n, bond_status_bus_i, all_aligned_i, tms, tck, tdi}),
    .q       (pin_s)
  );
  assign {trst_s, lead_s, quad_s, ref_s, inh_s, bus_s, all_in_s, tms_s, tck_s, tdi_s}
    = pin_s;
  assign le_s = {selftest_latch_enable, output_enable_latch_enable, rx_lane_latch_enable};

  logic dev_rst;
  assign dev_rst = !aresetn || !trst_s;

  logic [31:0]              ctrl_reg;
  logic [MDBC_IRQ_BITS-1:0] irq_st_reg, irq_en_reg, irq_ev;
  logic                     wr_fire;
  logic [31:0]              wr_data_reg;
  logic [7:0]               wr_addr_reg;

  logic [3:0] settle_reg;
  logic       settled;
  always_ff @(posedge aclk) begin
    if (dev_rst) begin
      settle_reg <= '0;
    end else if (!settled) begin
      settle_reg <= settle_reg + 4'h1;
    end
  end
  assign settled = (settle_reg == MDBC_SETTLE_CYCLES);

  // Lead select only counts in quad bonding on the reference clock
  logic mode_ok, bonded, is_master, is_slave, drive_bus, drive_all;
  logic all_framed, all_seen;
  assign mode_ok    = quad_s && ref_s;
  assign bonded     = quad_s && master_in_group;
  assign is_master  = mode_ok && !lead_s;
  assign is_slave   = mode_ok && lead_s;
  assign drive_bus  = is_master && bonded && settled && ctrl_reg[0];
  assign drive_all  = bonded && ref_s && settled;
  assign all_framed = &lane_framed;
  assign all_seen   = &lane_bond_seen;

  logic [1:0] status_reg;
  always_ff @(posedge aclk) begin
    if (dev_rst) begin
      status_reg  <= MDBC_CODE_NORMAL;
      rx_word_out <= '0;
    end else begin
      status_reg  <= local_status;
      rx_word_out <= rx_word_in;
    end
  end

  // Open drain: only low is driven, the pull-up supplies high
  assign bond_status_bus_o  = 2'h0;
  assign bond_status_bus_oe = drive_bus ? ~status_reg : 2'h0;
  assign all_aligned_o      = 1'b0;
  assign all_aligned_oe     = drive_all && !all_framed;

  always_ff @(posedge aclk) begin
    if (dev_rst || !bonded) begin
      align_permit <= '0;
    end else if (!inh_s) begin
      align_permit <= all_seen ? lane_bond_seen : '0;
    end else begin
      align_permit <= lane_bond_seen;
    end
  end

  always_ff @(posedge aclk) begin
    if (dev_rst) begin
      eb_resync  <= 1'b0;
      eb_insert  <= 1'b0;
      eb_delete  <= 1'b0;
      eb_pointer <= MDBC_EB_NOMINAL;
    end else begin
      eb_resync <= is_slave && settled && (bus_s == MDBC_CODE_SYNC);
      eb_insert <= is_slave && settled && (bus_s == MDBC_CODE_INSERT);
      eb_delete <= is_slave && settled && (bus_s == MDBC_CODE_DELETE);
      if (eb_resync) begin
        eb_pointer <= MDBC_EB_NOMINAL;
      end else if (eb_insert) begin
        eb_pointer <= eb_pointer + 4'h1;
      end else if (eb_delete) begin
        eb_pointer <= eb_pointer - 4'h1;
      end
    end
  end

  // Latches modelled as flops: one clock later than true transparency
  always_ff @(posedge aclk) begin
    if (dev_rst) begin
      selftest_en <= '0;
      output_en   <= '0;
      rx_lane_en  <= '0;
    end else begin
      if (le_s[2]) selftest_en <= latch_data;
      if (le_s[1]) output_en <= latch_data;
      if (le_s[0]) rx_lane_en <= latch_data;
    end
  end

  mdbc_tap_e  tap_reg, tap_next;
  logic       tck_prev, tck_rise, tck_fall, bypass_reg;
  logic [1:0] ir_reg;
  logic [2:0] tms_cnt;
  assign tck_rise = tck_s && !tck_prev;
  assign tck_fall = !tck_s && tck_prev;

  always_comb begin
    tap_next = tap_reg;
    case (tap_reg)
      MDBC_TLR:  tap_next = tms_s ? MDBC_TLR : MDBC_RTI;
      MDBC_RTI:  tap_next = tms_s ? MDBC_SDR : MDBC_RTI;
      MDBC_SDR:  tap_next = tms_s ? MDBC_SIR : MDBC_CDR;
      MDBC_CDR:  tap_next = tms_s ? MDBC_E1DR : MDBC_SHDR;
      MDBC_SHDR: tap_next = tms_s ? MDBC_E1DR : MDBC_SHDR;
      MDBC_E1DR: tap_next = tms_s ? MDBC_UDR : MDBC_PDR;
      MDBC_PDR:  tap_next = tms_s ? MDBC_E2DR : MDBC_PDR;
      MDBC_E2DR: tap_next = tms_s ? MDBC_UDR : MDBC_SHDR;
      MDBC_UDR:  tap_next = tms_s ? MDBC_SDR : MDBC_RTI;
      MDBC_SIR:  tap_next = tms_s ? MDBC_TLR : MDBC_CIR;
      MDBC_CIR:  tap_next = tms_s ? MDBC_E1IR : MDBC_SHIR;
      MDBC_SHIR: tap_next = tms_s ? MDBC_E1IR : MDBC_SHIR;
      MDBC_E1IR: tap_next = tms_s ? MDBC_UIR : MDBC_PIR;
      MDBC_PIR:  tap_next = tms_s ? MDBC_E2IR : MDBC_PIR;
      MDBC_E2IR: tap_next = tms_s ? MDBC_UIR : MDBC_SHIR;
      MDBC_UIR:  tap_next = tms_s ? MDBC_SDR : MDBC_RTI;
      default:   tap_next = MDBC_TLR;
    endcase
  end

  // Raw pin is the asynchronous reset; no edge on aclk is needed
  always_ff @(posedge aclk or negedge test_and_device_reset_n) begin
    if (!test_and_device_reset_n) begin
      tap_reg    <= MDBC_TLR;
      tms_cnt    <= '0;
      tck_prev   <= 1'b0;
      bypass_reg <= 1'b0;
      ir_reg     <= 2'h1;
      tdo_o      <= 1'b0;
    end else begin
      tck_prev <= tck_s;
      if (tck_rise) begin
        if (tms_s && tms_cnt < MDBC_TMS_RESET_CNT) tms_cnt <= tms_cnt + 3'h1;
        if (!tms_s) tms_cnt <= '0;
        if (tms_s && tms_cnt >= MDBC_TMS_RESET_CNT - 3'h1) begin
          tap_reg <= MDBC_TLR;
        end else begin
          tap_reg <= tap_next;
        end
        if (tap_reg == MDBC_SHDR) bypass_reg <= tdi_s;
        if (tap_reg == MDBC_CDR) bypass_reg <= 1'b0;
        if (tap_reg == MDBC_SHIR) ir_reg <= {tdi_s, ir_reg[1]};
        if (tap_reg == MDBC_CIR) ir_reg <= 2'h1;
      end
      if (tck_fall) begin
        tdo_o <= (tap_reg == MDBC_SHIR) ? ir_reg[0] : bypass_reg;
      end
    end
  end
  assign tdo_oe = (tap_reg == MDBC_SHDR) || (tap_reg == MDBC_SHIR);

  logic all_framed_prev, tap_tlr_prev;
  always_ff @(posedge aclk) begin
    if (dev_rst) begin
      all_framed_prev <= 1'b0;
      tap_tlr_prev    <= 1'b1;
    end else begin
      all_framed_prev <= all_framed;
      tap_tlr_prev    <= (tap_reg == MDBC_TLR);
    end
  end
  assign irq_ev = {(tap_reg == MDBC_TLR) && !tap_tlr_prev, eb_resync,
                   !all_framed && all_framed_prev, all_framed && !all_framed_prev};

  logic aw_held, w_held;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      wr_addr_reg  <= '0;
      wr_data_reg  <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= MDBC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held     <= 1'b1;
        wr_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held      <= 1'b1;
        wr_data_reg <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_addr_reg == MDBC_OFS_CTRL || wr_addr_reg == MDBC_OFS_IRQ_EN ||
                         wr_addr_reg == MDBC_OFS_IRQ_CLR) ? MDBC_RESP_OKAY : MDBC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Byte strobes are ignored: every field lives in the low byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg   <= MDBC_CTRL_RESET;
      irq_en_reg <= MDBC_IRQ_EN_RESET;
    end else if (wr_fire && wr_addr_reg == MDBC_OFS_CTRL) begin
      ctrl_reg <= {31'h0, wr_data_reg[0]};
    end else if (wr_fire && wr_addr_reg == MDBC_OFS_IRQ_EN) begin
      irq_en_reg <= wr_data_reg[MDBC_IRQ_BITS-1:0];
    end
  end

  // New events win over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_reg <= '0;
    end else if (wr_fire && wr_addr_reg == MDBC_OFS_IRQ_CLR) begin
      irq_st_reg <= (irq_st_reg & ~wr_data_reg[MDBC_IRQ_BITS-1:0]) | irq_ev;
    end else begin
      irq_st_reg <= irq_st_reg | irq_ev;
    end
  end
  assign irq = |(irq_st_reg & irq_en_reg);

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= MDBC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= MDBC_RESP_OKAY;
      case (s_axi_araddr)
        MDBC_OFS_CTRL:   s_axi_rdata <= ctrl_reg;
        MDBC_OFS_STATE:  s_axi_rdata <= {20'h0, eb_pointer, settled, drive_bus, is_master,
                                          all_framed, align_permit};
        MDBC_OFS_IRQ_ST: s_axi_rdata <= {28'h0, irq_st_reg};
        MDBC_OFS_IRQ_EN: s_axi_rdata <= {28'h0, irq_en_reg};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= MDBC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_status_code_drive: assert property (drive_bus |-> bond_status_bus_oe == ~status_reg)
    else $error("status bus drive does not match code");
  a_status_timing: assert property (##1 !dev_rst && !$past(dev_rst) |-> status_reg == $past(local_status))
    else $error("status code not aligned with data");
  a_status_gate: assert property (!(is_master && bonded) |-> bond_status_bus_oe == 2'h0)
    else $error("status bus driven outside master bonded mode");
  a_slave_release: assert property (lead_s |-> bond_status_bus_oe == 2'h0)
    else $error("slave drives status bus");
  a_lead_ignored: assert property (!mode_ok |-> !is_master && !is_slave)
    else $error("lead select used outside quad mode");
  a_flag_wired_and: assert property (all_aligned_oe |-> !all_framed && !all_aligned_o)
    else $error("all aligned flag wrong");
  a_flag_gate: assert property (!bonded || !ref_s |-> !all_aligned_oe)
    else $error("all aligned flag driven outside bonding");
  a_inhibit_block: assert property (!dev_rst && !inh_s && !all_seen ##1 !dev_rst |-> align_permit == '0)
    else $error("inhibit did not block alignment");
  a_free_align: assert property (!dev_rst && inh_s && bonded ##1 !dev_rst |-> align_permit == $past(lane_bond_seen))
    else $error("lane not allowed to align");
  a_master_group: assert property (!master_in_group |=> align_permit == '0)
    else $error("bonding without master channel");
  a_tms_reset: assert property (tck_rise && tms_s && tms_cnt == 3'h4 |=> tap_reg == MDBC_TLR)
    else $error("test controller not reset by mode select");
  a_tdo_release: assert property (tap_reg == MDBC_TLR || tap_reg == MDBC_RTI |-> !tdo_oe)
    else $error("test data driven outside shift");
  a_reset_state: assert property (dev_rst |=> eb_pointer == MDBC_EB_NOMINAL && !eb_insert)
    else $error("reset did not centre buffer");
  a_settle_time: assert property ($fell(dev_rst) |-> ##[1:15] settled)
    else $error("outputs not settled in time");
  a_latch_clear: assert property (dev_rst |=> selftest_en == '0 && output_en == '0 && rx_lane_en == '0)
    else $error("latches not cleared by reset");
  a_slave_apply: assert property (!dev_rst && is_slave && settled && bus_s == MDBC_CODE_DELETE ##1 !dev_rst |-> eb_delete)
    else $error("slave missed delete command");

  c_master_drive: cover property (drive_bus && status_reg == MDBC_CODE_INSERT);
  c_slave_resync: cover property (eb_resync);
  c_all_aligned: cover property (all_framed && drive_all);
  c_irq_raise: cover property ($rose(irq));
endmodule // mdbc_top

// file: mdbc_peer_model.sv
`timescale 1ns/1ps
module mdbc_peer_model
  import mdbc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       drive_en,
  input  wire logic [1:0] code,
  input  wire logic       peer_framed,
  input  wire logic [1:0] bus_level,
  output logic      [1:0] bus_oe,
  output logic            aligned_oe,
  output logic      [1:0] seen_code
);
  logic [1:0] code_reg;

  // Codes launch on the clock edge, as the peer's receive data would
  always_ff @(posedge aclk) begin
    code_reg  <= code;
    seen_code <= bus_level;
  end

  // Open drain: a 0 bit pulls low, a 1 bit leaves the pull-up to the wire
  assign bus_oe = drive_en ? ~code_reg : 2'h0;

  // A peer holds the flag low until its own lanes have framed
  assign aligned_oe = ~peer_framed;
endmodule // mdbc_peer_model

// file: mdbc_top_test.sv
`timescale 1ns/1ps
module mdbc_top_test
  import mdbc_pkg::*;
;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq, trst_n, lead_n, quad, on_ref;
  logic        inh_n, mig, aoe, st_le, oe_le, rx_le, tdo_o, tdo_oe, eb_rs, eb_in, eb_dl;
  logic        p_drv, p_framed, p_aoe, all_lvl, ao, tms, tck;
  logic [1:0]  bresp, rresp, loc_st, bus_o, bus_oe, p_oe, p_code, p_seen, bus_lvl, r;
  logic [3:0]  framed, seen, permit, eb_ptr, ldata, st_en, o_en, rx_en;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [39:0] rx_in, rx_out;
  int          bad_count, n_tests;

  // Pull-ups win unless some party pulls the line low
  assign bus_lvl = ~(bus_oe | p_oe);
  assign all_lvl = ~(aoe | p_aoe);
  always #20 aclk = ~aclk;

  mdbc_top i_mdbc_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq), .test_and_device_reset_n(trst_n), .lead_select_n(lead_n), .quad_bond(quad),
    .rx_on_ref_clock(on_ref), .align_inhibit_n(inh_n), .master_in_group(mig),
    .lane_framed(framed), .lane_bond_seen(seen), .local_status(loc_st), .rx_word_in(rx_in),
    .rx_word_out(rx_out), .bond_status_bus_i(bus_lvl), .bond_status_bus_o(bus_o),
    .bond_status_bus_oe(bus_oe), .all_aligned_i(all_lvl), .all_aligned_o(ao),
    .all_aligned_oe(aoe), .align_permit(permit), .eb_resync(eb_rs), .eb_insert(eb_in),
    .eb_delete(eb_dl), .eb_pointer(eb_ptr), .selftest_latch_enable(st_le),
    .output_enable_latch_enable(oe_le), .rx_lane_latch_enable(rx_le), .latch_data(ldata),
    .selftest_en(st_en), .output_en(o_en), .rx_lane_en(rx_en), .tms(tms), .tck(tck),
    .tdi(1'b0), .tdo_o(tdo_o), .tdo_oe(tdo_oe)
  );

  mdbc_peer_model i_mdbc_peer_model (
    .aclk(aclk), .drive_en(p_drv), .code(p_code), .peer_framed(p_framed),
    .bus_level(bus_lvl), .bus_oe(p_oe), .aligned_oe(p_aoe), .seen_code(p_seen)
  );

  task end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Ready is sampled on the falling edge, so the rising-edge handshake never races
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int   i;
    logic ga, gw, done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (i = 0; i < 50 && !done; i++) begin
      @(negedge aclk);
      ga = awvalid && (awready === 1'b1);
      gw = wvalid && (wready === 1'b1);
      done = (bvalid === 1'b1);
      rs = bresp;
      @(posedge aclk);
      if (ga) awvalid <= 1'b0;
      if (gw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!done) begin
      bad_count++;
      end_sim();
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int   i;
    logic ga, done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (i = 0; i < 50 && !done; i++) begin
      @(negedge aclk);
      ga = arvalid && (arready === 1'b1);
      done = (rvalid === 1'b1);
      v = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ga) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!done) begin
      bad_count++;
      end_sim();
    end
  endtask

  task t_regs();
    axi_rd(MDBC_OFS_CTRL, d, r);
    chk("ctrl reset", MDBC_CTRL_RESET, d);
    axi_rd(MDBC_OFS_IRQ_EN, d, r);
    chk("irq_en reset", MDBC_IRQ_EN_RESET, d);
    axi_rd(8'h40, d, r);
    chk("unmapped resp", MDBC_RESP_SLVERR, r);
    axi_wr(MDBC_OFS_STATE, 32'h0000_00FF, r);
    chk("ro write resp", MDBC_RESP_SLVERR, r);
  endtask

  task t_master();
    tick(1);
    #1 chk("bus delete", MDBC_CODE_DELETE, bus_lvl);
    chk("peer seen", MDBC_CODE_DELETE, p_seen);
    tick(1);
    loc_st <= MDBC_CODE_INSERT;
    rx_in  <= 40'hA5_5A00_C3C3;
    tick(1);
    #1 chk("bus insert", MDBC_CODE_INSERT, bus_lvl);
    chk("rx word", 40'hA5_5A00_C3C3, rx_out);
    tick(1);
    loc_st <= MDBC_CODE_NORMAL;
    tick(2);
    #1 chk("bus normal", MDBC_CODE_NORMAL, bus_lvl);
    tick(1);
    loc_st <= MDBC_CODE_SYNC;
    lead_n <= 1'b1;
    tick(4);
    #1 chk("oe as slave", 2'h0, bus_oe);
    tick(1);
    lead_n <= 1'b0;
    quad   <= 1'b0;
    tick(4);
    #1 chk("oe not quad", 2'h0, bus_oe);
    tick(1);
    quad   <= 1'b1;
    on_ref <= 1'b0;
    tick(4);
    #1 chk("oe not ref", 2'h0, bus_oe);
    tick(1);
    on_ref <= 1'b1;
    tick(4);
    #1 chk("bus sync", MDBC_CODE_SYNC, bus_lvl);
  endtask

  task automatic t_slave();
    logic [1:0] codes [4] = '{MDBC_CODE_INSERT, MDBC_CODE_DELETE, MDBC_CODE_SYNC,
                              MDBC_CODE_NORMAL};
    int         k;
    tick(1);
    lead_n <= 1'b1;
    p_drv  <= 1'b1;
    for (k = 0; k < 4; k++) begin
      tick(1);
      p_code <= codes[k];
      tick(5);
      #1 chk("eb actions", {codes[k] == 2'h0, codes[k] == 2'h1, codes[k] == 2'h2},
                           {eb_rs, eb_in, eb_dl});
    end
    chk("eb pointer", MDBC_EB_NOMINAL, eb_ptr);
    axi_rd(MDBC_OFS_IRQ_ST, d, r);
    chk("resync event", 32'h4, d & 32'h4);
    axi_wr(MDBC_OFS_IRQ_EN, 32'h4, r);
    #1 chk("irq raised", 1'b1, irq);
    axi_wr(MDBC_OFS_IRQ_CLR, 32'h4, r);
    #1 chk("irq cleared", 1'b0, irq);
    tick(1);
    p_drv  <= 1'b0;
    lead_n <= 1'b0;
  endtask

  task t_aligned();
    tick(1);
    framed <= 4'h7;
    tick(3);
    #1 chk("flag lane missing", 1'b0, all_lvl);
    tick(1);
    framed <= 4'hF;
    tick(3);
    #1 chk("flag all framed", 1'b1, all_lvl);
    tick(1);
    p_framed <= 1'b0;
    tick(2);
    #1 chk("flag wired and", 2'h0, {aoe, all_lvl});
    tick(1);
    p_framed <= 1'b1;
    quad     <= 1'b0;
    framed   <= 4'h7;
    tick(3);
    #1 chk("flag not quad", 1'b0, aoe);
    tick(1);
    quad <= 1'b1;
  endtask

  task t_permit();
    tick(1);
    inh_n <= 1'b0;
    seen  <= 4'h3;
    tick(3);
    #1 chk("permit inhibited", 4'h0, permit);
    tick(1);
    seen <= 4'hF;
    tick(3);
    #1 chk("permit all seen", 4'hF, permit);
    tick(1);
    inh_n <= 1'b1;
    seen  <= 4'h3;
    tick(3);
    #1 chk("permit free", 4'h3, permit);
    tick(1);
    mig <= 1'b0;
    tick(3);
    #1 chk("permit no master", 4'h0, permit);
    tick(1);
    mig <= 1'b1;
  endtask

  // Test clock runs at a ninth of aclk so every synchronised edge is seen
  task automatic tck_cycle(input logic m);
    tick(1);
    tms <= m;
    tck <= 1'b0;
    tick(4);
    tck <= 1'b1;
    tick(4);
  endtask

  task automatic t_tap();
    int k;
    for (k = 0; k < 4; k++) tck_cycle(k == 1);
    #1 chk("tdo in shift", 1'b1, tdo_oe);
    repeat (5) tck_cycle(1'b1);
    #1 chk("tdo after tms reset", 1'b0, tdo_oe);
    axi_rd(MDBC_OFS_IRQ_ST, d, r);
    chk("tap reset event", 32'h8, d & 32'h8);
    for (k = 0; k < 4; k++) tck_cycle(k == 1);
    #1 chk("tdo shift again", 1'b1, tdo_oe);
  endtask

  task t_reset();
    tick(1);
    ldata <= 4'hA; st_le <= 1'b1; oe_le <= 1'b1; rx_le <= 1'b1;
    tick(1);
    st_le <= 1'b0; oe_le <= 1'b0; rx_le <= 1'b0;
    tick(2);
    #1 chk("latches loaded", {3{4'hA}}, {st_en, o_en, rx_en});
    tick(1);
    trst_n <= 1'b0;
    #2 chk("tdo released", 1'b0, tdo_oe);
    tick(4);
    #1 chk("latches cleared", 12'h0, {st_en, o_en, rx_en});
    chk("pointer nominal", MDBC_EB_NOMINAL, eb_ptr);
    chk("permit reset", 4'h0, permit);
    tick(1);
    trst_n <= 1'b1;
    tick(15);
    #1 chk("bus after release", 2'h3, bus_oe);
  endtask

  initial begin
    aclk = 1'b0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    trst_n = 1'b1; lead_n = 1'b0; quad = 1'b1; on_ref = 1'b1; mig = 1'b1;
    inh_n = 1'b1;
    tms = 1'b1; tck = 1'b0;
    framed = 4'h0; seen = 4'h0; loc_st = MDBC_CODE_DELETE; rx_in = 40'h0;
    st_le = 1'b0; oe_le = 1'b0; rx_le = 1'b0; ldata = 4'h0;
    p_drv = 1'b0; p_framed = 1'b1; p_code = MDBC_CODE_NORMAL;
    bad_count = 0; n_tests = 0;
    // Pulse the pin so the test controller leaves its unknown power-up state
    tick(1);
    trst_n <= 1'b0;
    tick(1);
    aresetn <= 1'b1;
    trst_n  <= 1'b1;
    // Status drive must appear within the settle bound after release
    tick(15);
    t_master();
    t_regs();
    t_slave();
    t_aligned();
    t_permit();
    t_tap();
    t_reset();
    end_sim();
  end
endmodule // mdbc_top_test
